// >>> rtl/port_pair_strap_config.sv
// Purpose: reset-time strap capture for one lead/follower port pair
// Assumes: strap pins asynchronous to MCLK; RST released synchronously
// Notes:   one clock domain, clock enable freezes all state
`include "strap_map.svh"
`timescale 1ns/1ps
`default_nettype none

module port_pair_strap_config (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        CE,
  // register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // strap pins
  input  wire logic        PAIR_LANE_MODE_STRAP_I,
  output logic             PAIR_LANE_MODE_STRAP_O,
  output logic             PAIR_LANE_MODE_STRAP_OE,
  input  wire logic        LEAD_PORT_POWERDOWN_STRAP_I,
  output logic             LEAD_PORT_POWERDOWN_STRAP_O,
  output logic             LEAD_PORT_POWERDOWN_STRAP_OE,
  input  wire logic        FOLLOWER_PORT_POWERDOWN_STRAP_I,
  output logic             FOLLOWER_PORT_POWERDOWN_STRAP_O,
  output logic             FOLLOWER_PORT_POWERDOWN_STRAP_OE,
  // port controls
  output logic             CONFIG_DONE,
  output logic             LEAD_FOUR_LANE,
  output logic             FOLLOWER_AVAILABLE,
  output logic [3:0]       SERDES_POWERDOWN_CONTROL,
  output logic             FOLLOWER_POWERDOWN
);
  import strap_pkg::*;

  state_t s_q;
  state_t s_d;
  logic   lead_eff;
  logic   foll_eff;

  // ----------------------------------------
  // effective power-down
  // ----------------------------------------
  always_comb begin
    lead_eff = s_q.lead_pd;
    foll_eff = s_q.foll_pd;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h0;
    s_d.mode_sync = {s_q.mode_sync[0], PAIR_LANE_MODE_STRAP_I};
    s_d.lead_sync = {s_q.lead_sync[0], LEAD_PORT_POWERDOWN_STRAP_I};
    s_d.foll_sync = {s_q.foll_sync[0], FOLLOWER_PORT_POWERDOWN_STRAP_I};
    unique case (s_q.phase)
      ST_WAIT: begin
        if (s_q.cnt == 4'(`STRAP_SAMPLE_CYCLE)) begin
          // capture once at end of hold window
          s_d.mode    = s_q.mode_sync[1];
          s_d.lead_pd = s_q.lead_sync[1];
          s_d.foll_pd = s_q.foll_sync[1];
          s_d.phase   = ST_RUN;
        end else begin
          s_d.cnt = s_q.cnt + 4'h1;
        end
      end
      ST_RUN: begin
        if (WR && ADDR == `CLKSEL_OFFSET) begin
          s_d.lead_pd = WDATA[`CLKSEL_LEAD_PD_BIT];
          s_d.foll_pd = WDATA[`CLKSEL_FOLL_PD_BIT];
        end
      end
      default: s_d.phase = ST_WAIT;
    endcase
    if (WR && ADDR == `TEST_OFFSET) begin
      s_d.test = WDATA[3:0];
    end
    if (RD) begin
      unique case (ADDR)
        `CLKSEL_OFFSET: begin
          s_d.rdata[`CLKSEL_LEAD_PD_BIT] = s_q.lead_pd;
          s_d.rdata[`CLKSEL_FOLL_PD_BIT] = s_q.foll_pd;
        end
        `STATUS_OFFSET: begin
          s_d.rdata[0] = (s_q.phase == ST_RUN);
          s_d.rdata[1] = s_q.mode;
          s_d.rdata[2] = lead_eff;
          s_d.rdata[3] = lead_eff | foll_eff;
        end
        `TEST_OFFSET: s_d.rdata[3:0] = s_q.test;
        default:      s_d.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      s_q.phase     <= ST_WAIT;
      s_q.cnt       <= 4'h0;
      s_q.mode_sync <= 2'h0;
      s_q.lead_sync <= 2'h0;
      s_q.foll_sync <= 2'h0;
      s_q.mode      <= 1'b0;
      s_q.lead_pd   <= 1'b1;
      s_q.foll_pd   <= 1'b1;
      s_q.lead_ovr  <= 1'b0;
      s_q.foll_ovr  <= 1'b0;
      s_q.test      <= `TEST_RESET;
      s_q.rdata     <= 32'h0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_comb begin
    RDATA          = s_q.rdata;
    CONFIG_DONE    = (s_q.phase == ST_RUN);
    LEAD_FOUR_LANE = CONFIG_DONE && !s_q.mode;
    FOLLOWER_AVAILABLE = CONFIG_DONE && s_q.mode;
    SERDES_POWERDOWN_CONTROL = {4{lead_eff}};
    FOLLOWER_POWERDOWN = lead_eff | foll_eff;
    // pins driven only in test mode
    PAIR_LANE_MODE_STRAP_OE          = s_q.test[`TEST_EN_BIT];
    LEAD_PORT_POWERDOWN_STRAP_OE     = s_q.test[`TEST_EN_BIT];
    FOLLOWER_PORT_POWERDOWN_STRAP_OE = s_q.test[`TEST_EN_BIT];
    PAIR_LANE_MODE_STRAP_O           = s_q.test[`TEST_MODE_BIT];
    LEAD_PORT_POWERDOWN_STRAP_O      = s_q.test[`TEST_LEAD_BIT];
    FOLLOWER_PORT_POWERDOWN_STRAP_O  = s_q.test[`TEST_FOLL_BIT];
  end
endmodule

`default_nettype wire

// >>> rtl/strap_map.svh
// Function
// - mode strap low: lead port runs four lanes, follower port unavailable.
// - mode strap high: lead and follower run as independent single-lane ports.
// - mode strap captured only at reset release, later changes ignored; code captures it at end of hold window, 10 clocks after release.
// - lead powerdown strap low: lead powered up, follower follows its strap.
// - lead powerdown strap high: both ports powered down.
// - lead powerdown acts on all four lanes of the macro together.
// - follower powered up when its strap low, down when high.
// - powerdown straps steady 10 clocks after release; sampled then, ignored after.
// - software may override lead powerdown through the clock selection register.
// - software may override follower powerdown through the clock selection register.
// - strap pins are inputs normally, driven as outputs only in test mode.
//
// Purpose: offsets, fields and timing for the strap loader
// Assumes: 40 MHz reference clock
// Notes:   register offsets are byte addresses of 32-bit words
`ifndef STRAP_MAP_SVH
`define STRAP_MAP_SVH

`define CLK_PERIOD_NS       25
`define STRAP_HOLD_CYCLES   10
`define STRAP_SAMPLE_CYCLE  (`STRAP_HOLD_CYCLES - 1)

`define CLKSEL_OFFSET       8'h00
`define STATUS_OFFSET       8'h04
`define TEST_OFFSET         8'h08

// clock selection register fields
`define CLKSEL_LEAD_PD_BIT  0
`define CLKSEL_FOLL_PD_BIT  1
// test register fields
`define TEST_EN_BIT         0
`define TEST_MODE_BIT       1
`define TEST_LEAD_BIT       2
`define TEST_FOLL_BIT       3

`define CLKSEL_RESET        2'h0
`define TEST_RESET          4'h0

`endif

// >>> rtl/strap_pkg.sv
// Purpose: types for the strap loader
// Assumes: nothing
// Notes:   none
package strap_pkg;
  typedef enum logic [1:0] {ST_WAIT, ST_RUN} phase_t;

  typedef struct packed {
    phase_t     phase;
    logic [3:0] cnt;
    logic [1:0] mode_sync;
    logic [1:0] lead_sync;
    logic [1:0] foll_sync;
    logic       mode;
    logic       lead_pd;
    logic       foll_pd;
    logic       lead_ovr;
    logic       foll_ovr;
    logic [3:0] test;
    logic [31:0] rdata;
  } state_t;
endpackage

// >>> verif/strap_board.sv
// Purpose: board tie-offs on the three strap pins
// Assumes: tie levels set by the bench for each boot
// Notes: device drive wins while its enable is high
`timescale 1ns/1ps
`default_nettype none
module strap_board (
  input  wire logic [2:0] tie,
  input  wire logic [2:0] drv,
  input  wire logic [2:0] oe,
  output logic      [2:0] pin
);
  // resistor level unless driven in test mode
  assign pin = (oe & drv) | (~oe & tie);
endmodule
`default_nettype wire

// >>> verif/port_pair_strap_config_props.sv
// Purpose: port checks for the strap loader
// Assumes: CE held high
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module strap_props (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        WR,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        PAIR_LANE_MODE_STRAP_OE,
  input wire logic        CONFIG_DONE,
  input wire logic        LEAD_FOUR_LANE,
  input wire logic        FOLLOWER_AVAILABLE,
  input wire logic [3:0]  SERDES_POWERDOWN_CONTROL,
  input wire logic        FOLLOWER_POWERDOWN
);
  logic [3:0] n_q;
  logic       ow;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  assign ow = CONFIG_DONE && WR && ADDR == 8'h00;
  always_ff @(posedge MCLK or posedge RST)
    if (RST) n_q <= 4'h0;
    else if (n_q != 4'hf) n_q <= n_q + 4'h1;
  done_time_a: assert property (CONFIG_DONE == (n_q > 4'h9))
    else $error("done");
  mode_one_a: assert property (CONFIG_DONE |->
    LEAD_FOUR_LANE != FOLLOWER_AVAILABLE) else $error("mode");
  mode_held_a: assert property ($past(CONFIG_DONE) |->
    $stable(FOLLOWER_AVAILABLE)) else $error("held");
  pd_held_a: assert property ($past(CONFIG_DONE) && !$past(WR) |->
    $stable(SERDES_POWERDOWN_CONTROL)) else $error("pd");
  lanes_joint_a: assert property (
    SERDES_POWERDOWN_CONTROL inside {4'h0, 4'hf}) else $error("lanes");
  lead_both_a: assert property (SERDES_POWERDOWN_CONTROL[0] |->
    FOLLOWER_POWERDOWN) else $error("both");
  ovr_write_a: assert property (ow |=>
    {SERDES_POWERDOWN_CONTROL[0], FOLLOWER_POWERDOWN} ==
    {$past(WDATA[0]), $past(WDATA[0]) | $past(WDATA[1])}) else $error("ovr");
  test_oe_a: assert property (WR && ADDR == 8'h08 |=>
    PAIR_LANE_MODE_STRAP_OE == $past(WDATA[0])) else $error("oe");
  cover property ($rose(CONFIG_DONE));
  cover property (FOLLOWER_AVAILABLE && !FOLLOWER_POWERDOWN);
  cover property (PAIR_LANE_MODE_STRAP_OE);
endmodule
bind port_pair_strap_config strap_props u_props (.*);
`default_nettype wire

// >>> verif/port_pair_strap_config_test.sv
// Purpose: self-checking bench for the strap loader
// Assumes: CE tied high
// Notes: board ties change per boot
`timescale 1ns/1ps
`default_nettype none
module port_pair_strap_config_test;
  logic MCLK = 1'b0, RST = 1'b1, CE = 1'b1, WR = 1'b0, RD = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic [2:0] tie = 3'h7, pin, drv, oe;
  logic CONFIG_DONE, LEAD_FOUR_LANE, FOLLOWER_AVAILABLE, FOLLOWER_POWERDOWN;
  logic [3:0] SERDES_POWERDOWN_CONTROL;
  int num_errors = 0, cmp_count = 0;
  always #12.5 MCLK = ~MCLK;
  strap_board BOARD (.tie(tie), .drv(drv), .oe(oe), .pin(pin));
  port_pair_strap_config DUT (.*,
    .PAIR_LANE_MODE_STRAP_I(pin[2]), .PAIR_LANE_MODE_STRAP_O(drv[2]),
    .PAIR_LANE_MODE_STRAP_OE(oe[2]), .LEAD_PORT_POWERDOWN_STRAP_I(pin[1]),
    .LEAD_PORT_POWERDOWN_STRAP_O(drv[1]),
    .LEAD_PORT_POWERDOWN_STRAP_OE(oe[1]),
    .FOLLOWER_PORT_POWERDOWN_STRAP_I(pin[0]),
    .FOLLOWER_PORT_POWERDOWN_STRAP_O(drv[0]),
    .FOLLOWER_PORT_POWERDOWN_STRAP_OE(oe[0]));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    WR <= w;
    RD <= !w;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 1'b0;
    RD <= 1'b0;
    #1 if (!w) chk(RDATA, d);
  endtask
  task automatic outs(input logic [2:0] c);
    #1 chk(32'({LEAD_FOUR_LANE, FOLLOWER_AVAILABLE, SERDES_POWERDOWN_CONTROL,
      FOLLOWER_POWERDOWN}), 32'({!c[2], c[2], {4{c[1]}}, c[1] | c[0]}));
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    for (int i = 1; i < 8; i++) begin
      RST <= 1'b1;
      tie <= 3'(i);
      repeat (12) @(posedge MCLK);
      RST <= 1'b0;
      acc(1'b1, 8'h00, 32'h3);
      repeat (12) @(posedge MCLK);
      outs(3'(i));
      acc(1'b0, 8'h04, {28'h0, i[1] | i[0], i[1], i[2], 1'b1});
      tie <= ~3'(i);
      repeat (3) @(posedge MCLK);
      outs(3'(i));
    end
    for (int j = 0; j < 4; j++) begin
      acc(1'b1, 8'h00, 32'(j));
      outs({1'b1, j[0], j[1]});
    end
    acc(1'b0, 8'h0c, 32'h0);
    acc(1'b1, 8'h08, 32'h5);
    #1 chk(32'(pin), 32'h2);
    acc(1'b1, 8'h08, 32'h0);
    #1 chk(32'(pin), 32'h0);
    final_report;
  end
  initial begin
    repeat (5000) @(posedge MCLK);
    num_errors++;
    final_report;
  end
endmodule
`default_nettype wire
